// *** hdl/pfs_pkg.sv ***
// Purpose: constants for the port fault status flag bank
// Assumes: one 25 MHz core clock, register bytes reached by offset
// Notes:   offsets, bit positions, reset values and timing counts live here
package pfs_pkg;
   // register offsets (byte address on the internal register port)
   localparam logic [7:0] PFS_OFS_POWER_STATUS = 8'h1e;
   localparam logic [7:0] PFS_OFS_FAULT        = 8'h1f;
   localparam logic [7:0] PFS_OFS_EXT_STATUS   = 8'h20;
   localparam logic [7:0] PFS_OFS_COMMAND      = 8'h23;
   // fault_flags bit positions
   localparam int PFS_B_IF_ERR    = 0;
   localparam int PFS_B_VCONN_OC  = 1;
   localparam int PFS_B_BUS_OV    = 2;
   localparam int PFS_B_BUS_OC    = 3;
   localparam int PFS_B_FORCE_F   = 4;
   localparam int PFS_B_AUTO_F    = 5;
   // W1C flags occupy bits 5..0, bits 7..6 read zero here
   localparam logic [7:0] PFS_FAULT_W1C_MASK = 8'h3f;
   localparam logic [7:0] PFS_FAULT_RESET    = 8'h00;
   // extended status: safe-zero in bit 0, resets to one
   localparam int         PFS_B_SAFE0        = 0;
   localparam logic [7:0] PFS_EXT_RESET      = 8'h01;
   // power status bit holding the sensing-active flag, resets to one
   localparam int         PFS_B_SENSING      = 3;
   // command codes
   localparam logic [7:0] PFS_CMD_WAKE           = 8'h11;
   localparam logic [7:0] PFS_CMD_STOP_SENSING   = 8'h22;
   localparam logic [7:0] PFS_CMD_START_SENSING  = 8'h33;
   localparam logic [7:0] PFS_CMD_STOP_INTAKE    = 8'h44;
   localparam logic [7:0] PFS_CMD_START_INTAKE   = 8'h55;
   localparam logic [7:0] PFS_CMD_STOP_SUPPLY    = 8'h66;
   localparam logic [7:0] PFS_CMD_SUPPLY_BASE    = 8'h77;
   localparam logic [7:0] PFS_CMD_SUPPLY_RAISED  = 8'h88;
   localparam logic [7:0] PFS_CMD_LOOK4CONN      = 8'h99;
   localparam logic [7:0] PFS_CMD_RX_ONE_MORE    = 8'haa;
   localparam logic [7:0] PFS_CMD_ROLE_SWAP_SIG  = 8'hcc;
   localparam logic [7:0] PFS_CMD_RESET_TX_BUF   = 8'hdd;
   localparam logic [7:0] PFS_CMD_RESET_RX_BUF   = 8'hee;
   localparam logic [7:0] PFS_CMD_I2C_IDLE       = 8'hff;
   // transmit request types exempt from the short-buffer check
   localparam logic [2:0] PFS_TX_HARD_RESET = 3'h5;
   localparam logic [2:0] PFS_TX_CABLE_RST  = 3'h6;
   localparam logic [2:0] PFS_TX_BIST_MODE2 = 3'h7;
   localparam int         PFS_TX_MIN_BYTES  = 2;
   // drain time allowance in ms and its cycle count at 25 MHz
   localparam int PFS_CLK_HZ            = 25_000_000;
   localparam int PFS_DRAIN_TIME_MS     = 650;
   localparam int PFS_DRAIN_CYCLES      = PFS_DRAIN_TIME_MS * (PFS_CLK_HZ / 1000);
endpackage

// *** hdl/pfs_drain_timer.sv ***
// Purpose: watches one discharge request against the drain time allowance
// Assumes: request and safe-zero level synchronous to clk
// Notes:   fail pulses once per unbroken drain (request held, bus above safe zero) that outlives the allowance
`timescale 1ns/1ns
`default_nettype none
module pfs_drain_timer #(
   parameter int LIMIT = 16
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic request,
   input  wire logic safe0,
   output logic      fail
);
   import pfs_pkg::*;
   localparam int CW = $clog2(LIMIT + 1);
   logic [CW-1:0] count;
   logic          done;
   wire           running = request && !safe0 && !done;
   wire           expire  = running && (count == CW'(LIMIT - 1));
   ////////////////////////////////////////////////////////////////
   // count while draining; reaching safe zero or dropping the request rearms
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= '0;
         done  <= 1'b0;
         fail  <= 1'b0;
      end else begin
         count <= running ? count + CW'(1) : '0;
         done  <= (request && !safe0) ? (done | expire) : 1'b0;
         fail  <= expire;
      end
   end
endmodule
`default_nettype wire

// *** hdl/pfs_fault_bank.sv ***
// Purpose: fault status flags, extended safe-zero status and sensing state
// Assumes: register port strobes are single-cycle and synchronous to clk
// Notes:   W1C clears lose to a same-cycle set or a persisting condition
`timescale 1ns/1ns
`default_nettype none
module pfs_fault_bank #(
   parameter int DRAIN_CYCLES = pfs_pkg::PFS_DRAIN_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   input  wire logic       discharge_on_detach_enable,
   input  wire logic       detached,
   input  wire logic       forced_bus_drain,
   input  wire logic       bus_below_safe0,
   input  wire logic       bus_current_limit,
   input  wire logic       bus_overvoltage,
   input  wire logic       vconn_overcurrent,
   input  wire logic       sourcing_bus,
   input  wire logic       sinking_bus,
   input  wire logic       tx_request,
   input  wire logic [2:0] tx_type,
   input  wire logic [7:0] tx_buf_count,
   input  wire logic       tx_count_mismatch,
   input  wire logic       conn_invalid,
   output logic [7:0]      fault_flags,
   output logic            bus_sensing_active,
   output logic            safe0_flag
);
   import pfs_pkg::*;

   logic [7:0] extended_vbus_status;
   logic       conn_invalid_q;
   logic       auto_fail;
   logic       force_fail;
   logic [7:0] next_fault;
   logic [7:0] next_rdata;

   ////////////////////////////////////////////////////////////////
   // write decode
   wire fault_wr   = reg_wr && (reg_addr == PFS_OFS_FAULT);
   wire cmd_wr     = reg_wr && (reg_addr == PFS_OFS_COMMAND);
   wire [7:0] w1c  = fault_wr ? (reg_wdata & PFS_FAULT_W1C_MASK) : 8'h00;
   wire powered    = sourcing_bus || sinking_bus;

   // command validity
   wire cmd_known  = (reg_wdata == PFS_CMD_WAKE)          ||
                     (reg_wdata == PFS_CMD_STOP_SENSING)  ||
                     (reg_wdata == PFS_CMD_START_SENSING) ||
                     (reg_wdata == PFS_CMD_STOP_INTAKE)   ||
                     (reg_wdata == PFS_CMD_START_INTAKE)  ||
                     (reg_wdata == PFS_CMD_STOP_SUPPLY)   ||
                     (reg_wdata == PFS_CMD_SUPPLY_BASE)   ||
                     (reg_wdata == PFS_CMD_LOOK4CONN)     ||
                     (reg_wdata == PFS_CMD_RX_ONE_MORE)   ||
                     (reg_wdata == PFS_CMD_RESET_TX_BUF)  ||
                     (reg_wdata == PFS_CMD_RESET_RX_BUF)  ||
                     (reg_wdata == PFS_CMD_I2C_IDLE);
   // raised supply and role swap are decoded but treated as invalid
   wire err_cmd_bad   = cmd_wr && !cmd_known;
   wire err_stop_sens = cmd_wr && (reg_wdata == PFS_CMD_STOP_SENSING) && powered;
   wire err_intake    = cmd_wr && (reg_wdata == PFS_CMD_START_INTAKE) && sourcing_bus;
   wire err_base      = cmd_wr && (reg_wdata == PFS_CMD_SUPPLY_BASE) && sinking_bus;
   wire stop_sens_ok  = cmd_wr && (reg_wdata == PFS_CMD_STOP_SENSING) && !powered;
   wire start_sens    = cmd_wr && (reg_wdata == PFS_CMD_START_SENSING);

   // transmit checks; resets and carrier mode are exempt from the short-buffer check only
   wire tx_exempt  = (tx_type == PFS_TX_HARD_RESET) || (tx_type == PFS_TX_CABLE_RST) ||
                     (tx_type == PFS_TX_BIST_MODE2);
   wire err_tx_short = tx_request && !tx_exempt &&
                       (tx_buf_count < 8'(PFS_TX_MIN_BYTES));
   wire err_tx_count = tx_request && tx_count_mismatch;
   // only the entry into the invalid state counts as an event
   wire err_conn     = conn_invalid && !conn_invalid_q;

   wire err_any = err_cmd_bad || err_stop_sens || err_intake || err_base ||
                  err_tx_short || err_tx_count || err_conn;

   ////////////////////////////////////////////////////////////////
   // discharge watchdogs share one timer design
   pfs_drain_timer #(.LIMIT(DRAIN_CYCLES)) u_auto_timer (
      .clk     (clk),
      .arst_n  (arst_n),
      .request (discharge_on_detach_enable && detached),
      .safe0   (bus_below_safe0),
      .fail    (auto_fail)
   );
   pfs_drain_timer #(.LIMIT(DRAIN_CYCLES)) u_force_timer (
      .clk     (clk),
      .arst_n  (arst_n),
      .request (forced_bus_drain),
      .safe0   (bus_below_safe0),
      .fail    (force_fail)
   );

   ////////////////////////////////////////////////////////////////
   // set wins over clear; live conditions hold their flag against W1C
   wire [7:0] set_vec = {2'b00, auto_fail, force_fail, bus_current_limit,
                         bus_overvoltage, vconn_overcurrent, err_any};
   assign next_fault = ((fault_flags & ~w1c) | set_vec) & PFS_FAULT_W1C_MASK;

   // safe-zero only tracks the bus while sensing is on
   wire next_safe0 = bus_sensing_active ? bus_below_safe0 : safe0_flag;
   assign extended_vbus_status = {7'h00, safe0_flag};

   // read mux; unmapped offsets read zero
   assign next_rdata =
      (reg_addr == PFS_OFS_FAULT)        ? fault_flags :
      (reg_addr == PFS_OFS_EXT_STATUS)   ? extended_vbus_status :
      (reg_addr == PFS_OFS_POWER_STATUS) ? {4'h0, bus_sensing_active, 3'h0} : 8'h00;

   ////////////////////////////////////////////////////////////////
   // flag and status registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_flags    <= PFS_FAULT_RESET;
         safe0_flag     <= PFS_EXT_RESET[PFS_B_SAFE0];
         conn_invalid_q <= 1'b0;
         reg_rdata      <= 8'h00;
      end else begin
         fault_flags    <= next_fault;
         safe0_flag     <= next_safe0;
         conn_invalid_q <= conn_invalid;
         reg_rdata      <= next_rdata;
      end
   end

   // sensing enable; powered stop requests are dropped
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_sensing_active <= 1'b1;
      end else if (stop_sens_ok) begin
         bus_sensing_active <= 1'b0;
      end else if (start_sens) begin
         bus_sensing_active <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks
   property p_ocp_sticky;
      @(posedge clk) disable iff (!arst_n)
      bus_current_limit |=> fault_flags[PFS_B_BUS_OC];
   endproperty
   a_ocp_sticky: assert property (p_ocp_sticky) else $error("bus oc flag lost");

   property p_ov_sticky;
      @(posedge clk) disable iff (!arst_n)
      (bus_overvoltage && fault_wr) |=> fault_flags[PFS_B_BUS_OV];
   endproperty
   a_ov_sticky: assert property (p_ov_sticky) else $error("ov flag cleared");

   property p_vconn_sticky;
      @(posedge clk) disable iff (!arst_n)
      vconn_overcurrent |=> fault_flags[PFS_B_VCONN_OC];
   endproperty
   a_vconn_sticky: assert property (p_vconn_sticky) else $error("vconn flag lost");

   property p_bad_cmd;
      @(posedge clk) disable iff (!arst_n)
      (cmd_wr && (reg_wdata == PFS_CMD_ROLE_SWAP_SIG)) |=> fault_flags[PFS_B_IF_ERR];
   endproperty
   a_bad_cmd: assert property (p_bad_cmd) else $error("role swap not flagged");

   property p_stop_powered;
      @(posedge clk) disable iff (!arst_n)
      (err_stop_sens && bus_sensing_active) |=> bus_sensing_active && fault_flags[PFS_B_IF_ERR];
   endproperty
   a_stop_powered: assert property (p_stop_powered) else $error("stop sensing misled");

   property p_reserved;
      @(posedge clk) disable iff (!arst_n)
      fault_flags[7:6] == 2'b00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_w1c;
      @(posedge clk) disable iff (!arst_n)
      (fault_wr && reg_wdata[PFS_B_BUS_OC] && !bus_current_limit)
      |=> !fault_flags[PFS_B_BUS_OC];
   endproperty
   a_w1c: assert property (p_w1c) else $error("w1c did not clear");

   property p_safe0;
      @(posedge clk) disable iff (!arst_n)
      bus_sensing_active |=> safe0_flag == $past(bus_below_safe0);
   endproperty
   a_safe0: assert property (p_safe0) else $error("safe zero mismatch");

   property p_force_fail;
      @(posedge clk) disable iff (!arst_n)
      force_fail |=> fault_flags[PFS_B_FORCE_F];
   endproperty
   a_force_fail: assert property (p_force_fail) else $error("force fail lost");

   ////////////////////////////////////////////////////////////////
   // further views; tx, conn, read and safe-zero hold checks use the ports, the rest use auto_fail, cmd_wr or fault_wr
   property p_auto_fail;
      @(posedge clk) disable iff (!arst_n)
      auto_fail |=> fault_flags[PFS_B_AUTO_F];
   endproperty
   a_auto_fail: assert property (p_auto_fail) else $error("auto fail lost");

   property p_tx_short;
      @(posedge clk) disable iff (!arst_n)
      (tx_request && (tx_type < PFS_TX_HARD_RESET) && (tx_buf_count < 8'(PFS_TX_MIN_BYTES)))
      |=> fault_flags[PFS_B_IF_ERR];
   endproperty
   a_tx_short: assert property (p_tx_short) else $error("short tx not flagged");

   property p_tx_count;
      @(posedge clk) disable iff (!arst_n)
      (tx_request && tx_count_mismatch) |=> fault_flags[PFS_B_IF_ERR];
   endproperty
   a_tx_count: assert property (p_tx_count) else $error("count mismatch not flagged");

   property p_conn;
      @(posedge clk) disable iff (!arst_n)
      $rose(conn_invalid) |=> fault_flags[PFS_B_IF_ERR];
   endproperty
   a_conn: assert property (p_conn) else $error("invalid state not flagged");

   property p_raised_cmd;
      @(posedge clk) disable iff (!arst_n)
      (cmd_wr && (reg_wdata == PFS_CMD_SUPPLY_RAISED)) |=> fault_flags[PFS_B_IF_ERR];
   endproperty
   a_raised_cmd: assert property (p_raised_cmd) else $error("raised supply accepted");

   property p_intake;
      @(posedge clk) disable iff (!arst_n)
      (cmd_wr && (reg_wdata == PFS_CMD_START_INTAKE) && sourcing_bus) |=> fault_flags[PFS_B_IF_ERR];
   endproperty
   a_intake: assert property (p_intake) else $error("intake while supplying");

   property p_base;
      @(posedge clk) disable iff (!arst_n)
      (cmd_wr && (reg_wdata == PFS_CMD_SUPPLY_BASE) && sinking_bus) |=> fault_flags[PFS_B_IF_ERR];
   endproperty
   a_base: assert property (p_base) else $error("base supply while sinking");

   property p_stop_ok;
      @(posedge clk) disable iff (!arst_n)
      (cmd_wr && (reg_wdata == PFS_CMD_STOP_SENSING) && !sourcing_bus && !sinking_bus)
      |=> !bus_sensing_active;
   endproperty
   a_stop_ok: assert property (p_stop_ok) else $error("stop sensing ignored");

   property p_start_sens;
      @(posedge clk) disable iff (!arst_n)
      (cmd_wr && (reg_wdata == PFS_CMD_START_SENSING)) |=> bus_sensing_active;
   endproperty
   a_start_sens: assert property (p_start_sens) else $error("start sensing ignored");

   property p_safe0_hold;
      @(posedge clk) disable iff (!arst_n)
      !bus_sensing_active |=> $stable(safe0_flag);
   endproperty
   a_safe0_hold: assert property (p_safe0_hold) else $error("safe zero moved");

   property p_ext_read;
      @(posedge clk) disable iff (!arst_n)
      (reg_addr == PFS_OFS_EXT_STATUS) |=> (reg_rdata[7:1] == 7'h00);
   endproperty
   a_ext_read: assert property (p_ext_read) else $error("ext reserved bits set");

   property p_fault_read;
      @(posedge clk) disable iff (!arst_n)
      (reg_addr == PFS_OFS_FAULT) |=> (reg_rdata == $past(fault_flags));
   endproperty
   a_fault_read: assert property (p_fault_read) else $error("fault readback wrong");

   property p_zero_write;
      @(posedge clk) disable iff (!arst_n)
      (fault_wr && !reg_wdata[PFS_B_BUS_OV] && fault_flags[PFS_B_BUS_OV])
      |=> fault_flags[PFS_B_BUS_OV];
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("zero write cleared");

   property p_clr_ov;
      @(posedge clk) disable iff (!arst_n)
      (fault_wr && reg_wdata[PFS_B_BUS_OV] && !bus_overvoltage) |=> !fault_flags[PFS_B_BUS_OV];
   endproperty
   a_clr_ov: assert property (p_clr_ov) else $error("ov clear failed");

   property p_clr_vconn;
      @(posedge clk) disable iff (!arst_n)
      (fault_wr && reg_wdata[PFS_B_VCONN_OC] && !vconn_overcurrent)
      |=> !fault_flags[PFS_B_VCONN_OC];
   endproperty
   a_clr_vconn: assert property (p_clr_vconn) else $error("vconn clear failed");
endmodule
`default_nettype wire

// *** tb/pfs_manager.sv ***
// Purpose: port manager model on the far side of the register port
// Assumes: one access at a time, launched just after a rising edge
// Notes:   reserved fault bits are always written as zero
`timescale 1ns/1ns
`default_nettype none
module pfs_manager (
   input  wire logic       clk,
   output logic            reg_wr,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       bus_sensing_active
);
   import pfs_pkg::*;
   initial begin
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one-cycle strobe, data scrambled afterwards so stale bytes never pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= (a == PFS_OFS_FAULT) ? (d & PFS_FAULT_W1C_MASK) : d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // read data is registered: taken mid-cycle after the loading edge, returns on a rising edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      @(posedge clk);
      @(negedge clk);
      d = reg_rdata;
      @(posedge clk);
   endtask
   // safe-zero reading carries its own validity
   task automatic rd_safe0(output logic valid, output logic s0);
      logic [7:0] d;
      rd(PFS_OFS_EXT_STATUS, d);
      valid = bus_sensing_active;
      s0 = d[0];
   endtask
endmodule
`default_nettype wire

// *** tb/port_fault_status_flags_test.sv ***
// Purpose: self-checking bench for the fault status flag bank
// Assumes: drain allowance shortened to DRAIN cycles
// Notes:   inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ns
`default_nettype none
module port_fault_status_flags_test;
   import pfs_pkg::*;
   localparam int DRAIN = 16;
   logic       clk, arst_n, auto_en, detached, force_en, below, oc, ov, voc;
   logic       src, snk, tx_req, mism, conn_bad, reg_wr, sens, s0f, v, s;
   logic [2:0] tx_type;
   logic [7:0] tx_cnt, reg_addr, reg_wdata, reg_rdata, flags, d;
   int         err_count, n_checks, cycles;
   logic [7:0] cmds[4] = '{8'h88, 8'hcc, 8'hbb, 8'h11};
   pfs_fault_bank #(.DRAIN_CYCLES(DRAIN)) dut (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .discharge_on_detach_enable(auto_en), .detached(detached), .forced_bus_drain(force_en),
      .bus_below_safe0(below), .bus_current_limit(oc), .bus_overvoltage(ov),
      .vconn_overcurrent(voc), .sourcing_bus(src), .sinking_bus(snk), .tx_request(tx_req),
      .tx_type(tx_type), .tx_buf_count(tx_cnt), .tx_count_mismatch(mism),
      .conn_invalid(conn_bad), .fault_flags(flags), .bus_sensing_active(sens),
      .safe0_flag(s0f));
   pfs_manager mgr (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .bus_sensing_active(sens));
   ////////////////////////////////////////////////////////////////////////////
   always #20 clk = ~clk;
   // run is a few hundred cycles; a hang ends it as a failure at cycle 8000
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      if (err_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // checks land mid-cycle, return on a rising edge for the next drive
   task automatic look(input logic [7:0] f, input logic sa);
      @(posedge clk);
      @(negedge clk);
      chk(flags, f, "flags");
      chk({7'h0, sens}, {7'h0, sa}, "sensing");
      @(posedge clk);
   endtask
   task automatic expect_if(input logic e, input logic sa);
      look({7'h0, e}, sa);
      mgr.wr(PFS_OFS_FAULT, 8'h01);
      look(8'h00, sa);
   endtask
   task automatic tx(input logic [2:0] t, input logic [7:0] n, input logic m);
      tx_req <= 1'b1;
      tx_type <= t;
      tx_cnt <= n;
      mism <= m;
      @(posedge clk);
      tx_req <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      mgr.rd(PFS_OFS_FAULT, d);
      chk(d, 8'h00, "fault reset");
      mgr.rd(PFS_OFS_EXT_STATUS, d);
      chk(d, 8'h01, "ext reset");
   endtask
   // each fault stays through a clear while present, zero write keeps it
   task automatic t_sticky();
      for (int i = 1; i <= 3; i++) begin
         {oc, ov, voc} <= {i == 3, i == 2, i == 1};
         look(8'h01 << i, 1'b1);
         mgr.wr(PFS_OFS_FAULT, 8'h01 << i);
         look(8'h01 << i, 1'b1);
         {oc, ov, voc} <= 3'b000;
         mgr.wr(PFS_OFS_FAULT, 8'h00);
         look(8'h01 << i, 1'b1);
         mgr.wr(PFS_OFS_FAULT, 8'hff);
         look(8'h00, 1'b1);
      end
   endtask
   task automatic t_drain();
      {auto_en, detached, below} <= 3'b110;
      mgr.rd_safe0(v, s);
      chk({6'h0, v, s}, 8'h02, "safe0 low");
      // still inside the allowance: no failure yet
      repeat (DRAIN - 8) @(posedge clk);
      look(8'h00, 1'b1);
      repeat (8) @(posedge clk);
      look(8'h20, 1'b1);
      {auto_en, detached} <= 2'b00;
      mgr.wr(PFS_OFS_FAULT, 8'h20);
      look(8'h00, 1'b1);
      force_en <= 1'b1;
      repeat (DRAIN - 8) @(posedge clk);
      below <= 1'b1;
      repeat (DRAIN + 4) @(posedge clk);
      look(8'h00, 1'b1);
      below <= 1'b0;
      repeat (DRAIN + 4) @(posedge clk);
      look(8'h10, 1'b1);
      force_en <= 1'b0;
      mgr.wr(PFS_OFS_FAULT, 8'h10);
      look(8'h00, 1'b1);
   endtask
   task automatic t_iferr();
      tx(3'h0, 8'h01, 1'b0);
      expect_if(1'b1, 1'b1);
      for (int t = 5; t <= 7; t++) begin
         tx(3'(t), 8'h01, 1'b0);
         expect_if(1'b0, 1'b1);
      end
      tx(3'h0, 8'h02, 1'b0);
      expect_if(1'b0, 1'b1);
      tx(3'h0, 8'h04, 1'b1);
      expect_if(1'b1, 1'b1);
      conn_bad <= 1'b1;
      expect_if(1'b1, 1'b1);
      conn_bad <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         mgr.wr(PFS_OFS_COMMAND, cmds[i]);
         expect_if(i != 3, 1'b1);
      end
      src <= 1'b1;
      mgr.wr(PFS_OFS_COMMAND, PFS_CMD_STOP_SENSING);
      expect_if(1'b1, 1'b1);
      mgr.wr(PFS_OFS_COMMAND, PFS_CMD_START_INTAKE);
      expect_if(1'b1, 1'b1);
      {src, snk} <= 2'b01;
      mgr.wr(PFS_OFS_COMMAND, PFS_CMD_STOP_SENSING);
      expect_if(1'b1, 1'b1);
      mgr.wr(PFS_OFS_COMMAND, PFS_CMD_SUPPLY_BASE);
      expect_if(1'b1, 1'b1);
      snk <= 1'b0;
      mgr.wr(PFS_OFS_COMMAND, PFS_CMD_STOP_SENSING);
      expect_if(1'b0, 1'b0);
      // bus reaches zero while sensing is off: the flag keeps its old value
      below <= 1'b1;
      mgr.rd_safe0(v, s);
      chk({6'h0, v, s}, 8'h00, "safe0 held");
      mgr.wr(PFS_OFS_COMMAND, PFS_CMD_START_SENSING);
      expect_if(1'b0, 1'b1);
      mgr.rd_safe0(v, s);
      chk({6'h0, v, s}, 8'h03, "safe0 tracks again");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      // bus starts at safe zero, no power role taken
      {auto_en, detached, force_en, below, oc, ov, voc, src, snk} = 9'h020;
      {tx_req, mism, conn_bad, tx_type, tx_cnt} = 14'h0000;
      repeat (12) @(posedge clk);
      chk(flags, 8'h00, "flags in reset");
      chk({6'h0, sens, s0f}, 8'h03, "status in reset");
      chk(reg_rdata, 8'h00, "rdata in reset");
      arst_n <= 1'b1;
      t_reset();
      t_sticky();
      t_drain();
      t_iferr();
      give_verdict();
   end
endmodule
`default_nettype wire
